// [rtl/gpib_interface_message_control.sv]
`timescale 1ns/10ps
`default_nettype none
// Operation
// RULE1: Own talk address under ATN makes the device addressed talker.
// RULE2: Addressed talker sends its output bytes once ATN is released.
// RULE3: Own listen address under ATN makes the device addressed listener.
// RULE4: Go-to-local moves control to the local state.
// RULE5: Device clear discards pending input, output and unexecuted settings.
// RULE6: Device clear clears errors and waiting events except power-on.
// RULE7: Device clear withdraws service request unless raised only by power-on; code keeps srq up whenever srqPwr_reg is still set.
// RULE8: Selected clear acts like device clear only when addressed listener.
// RULE9: Lockout in remote disables front-panel keys at once.
// RULE10: Lockout in local keeps keys until remote is next entered.
// RULE11: Serial poll enabled talker sends the status byte instead of data.
// RULE12: Serial poll disable returns the talker to normal data.
// RULE13: Unlisten drops listener state, untalk drops talker state.
// RULE14: Interface clear drops both talker and listener states.
// RULE15: Power-up enters local control with panel keys working.
// RULE16: Own listen address in local moves control to remote.
// RULE17: Panel operation in remote returns control to local.
// RULE18: Lockout under ATN goes to remote or local lockout.
// RULE19: Local lockout keeps keys; listen address with REN goes remote lockout.
// RULE20: Remote lockout ignores every panel operation.
// RULE21: Releasing REN ends remote lockout.
// RULE22: Message unit is optional colon, header, optional space and argument.
// RULE23: Headers are classed simple, compound or common, command or query.
// RULE24: Bus address 31 detaches the device from the bus.
// RULE25: Messages end with line feed plus EOI, both ways.
// RULE26: Power-up leaves device unaddressed and outside serial poll.
module gpib_interface_message_control
	import gpib_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       atn,
	input  wire logic       ren,
	input  wire logic       ifc,
	input  wire logic [4:0] busAddr,
	input  wire logic       cmdValid,
	input  wire logic [7:0] cmdByte,
	input  wire logic       rxValid,
	input  wire logic [7:0] rxByte,
	input  wire logic       rxEoi,
	output logic            rxAccept,
	input  wire logic       outValid,
	input  wire logic [7:0] outByte,
	input  wire logic       outLast,
	output logic            outReady,
	input  wire logic [7:0] statusByte,
	output logic            txValid,
	output logic [7:0]      txByte,
	output logic            txEoi,
	input  wire logic       txReady,
	input  wire logic       panelOp,
	output logic            panelKeysEn,
	output logic            remote,
	output logic            lockout,
	output logic            talker,
	output logic            listener,
	output logic            serialPoll,
	output logic            devClear,
	input  wire logic       errEvent,
	output logic            errPending,
	input  wire logic       powerOnAck,
	output logic            powerOnPending,
	input  wire logic       srqReq,
	output logic            srq,
	output logic            dataValid,
	output logic [7:0]      dataByte,
	output logic            msgEnd,
	output logic            hdrValid,
	output logic [1:0]      hdrKind,
	output logic            hdrQuery
);
	// ==========================================================
	// Declarations
	msg_if m ();
	ctl_state_e ctl_reg;
	ctl_state_e ctl_next;
	logic talk_reg;
	logic listen_reg;
	logic spoll_reg;
	logic clear_reg;
	logic err_reg;
	logic pwrPend_reg;
	logic srqOther_reg;
	logic srqPwr_reg;
	logic txValid_reg;
	logic [7:0] txByte_reg;
	logic txEoi_reg;
	logic dataValid_reg;
	logic [7:0] dataByte_reg;
	logic msgEnd_reg;
	logic clearHit;
	logic txSlot;
	logic rxTake;
	logic rxEnd;
	logic [7:0] pollByte;

	// ==========================================================
	// Message decode and header classing
	msg_decoder u_dec (
		.cmdValid (cmdValid),
		.cmdByte  (cmdByte),
		.atn      (atn),
		.busAddr  (busAddr),
		.m        (m.dec)
	);

	header_classifier u_hdr (
		.clk       (clk),
		.rst       (rst),
		.flush     (clearHit),
		.byteValid (rxTake),
		.byteIn    (rxByte),
		.msgEnd    (rxEnd),
		.hdrValid  (hdrValid),
		.hdrKind   (hdrKind),
		.hdrQuery  (hdrQuery)
	);

	// ==========================================================
	// Talker and listener addressing
	// RULE26 idle at power-up
	always_ff @(posedge clk) begin
		if (rst) begin
			talk_reg <= 1'b0;
		end else if (ifc || m.unt || m.ota || m.mla) begin
			// RULE14 interface clear
			talk_reg <= 1'b0;
		end else if (m.mta) begin
			// RULE1 become talker
			talk_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			listen_reg <= 1'b0;
		end else if (ifc || m.unl || m.mta) begin
			// RULE13 unlisten
			listen_reg <= 1'b0;
		end else if (m.mla) begin
			// RULE3 become listener
			listen_reg <= 1'b1;
		end
	end

	// Serial poll mode; interface clear also leaves it
	always_ff @(posedge clk) begin
		if (rst || ifc) begin
			spoll_reg <= 1'b0;
		end else if (m.spd) begin
			// RULE12 poll disable
			spoll_reg <= 1'b0;
		end else if (m.spe) begin
			spoll_reg <= 1'b1;
		end
	end

	// ==========================================================
	// Remote, local and lockout control
	// Go-to-local is an addressed command, so only a listener obeys it
	always_comb begin
		ctl_next = ctl_reg;
		if (!ren) begin
			// RULE21 REN released
			ctl_next = CTL_LOCAL;
		end else if (m.llo) begin
			// RULE9 RULE10 RULE18 enter lockout
			ctl_next = (ctl_reg == CTL_REMOTE || ctl_reg == CTL_REMOTE_LO)
				? CTL_REMOTE_LO : CTL_LOCAL_LO;
		end else if (m.mla) begin
			case (ctl_reg)
				// RULE16 listen goes remote
				CTL_LOCAL:    ctl_next = CTL_REMOTE;
				// RULE19 lockout remote
				CTL_LOCAL_LO: ctl_next = CTL_REMOTE_LO;
				default:      ctl_next = ctl_reg;
			endcase
		end else if (m.gtl && listen_reg) begin
			case (ctl_reg)
				// RULE4 go to local
				CTL_REMOTE:    ctl_next = CTL_LOCAL;
				CTL_REMOTE_LO: ctl_next = CTL_LOCAL_LO;
				default:       ctl_next = ctl_reg;
			endcase
		end else if (panelOp && ctl_reg == CTL_REMOTE) begin
			// RULE17 panel returns local
			ctl_next = CTL_LOCAL;
		end
	end

	// RULE15 local at power-up
	always_ff @(posedge clk) begin
		if (rst) begin
			ctl_reg <= CTL_LOCAL;
		end else begin
			ctl_reg <= ctl_next;
		end
	end

	// RULE20 keys dead in remote and remote lockout
	assign panelKeysEn = (ctl_reg == CTL_LOCAL) || (ctl_reg == CTL_LOCAL_LO);
	assign remote      = (ctl_reg == CTL_REMOTE) || (ctl_reg == CTL_REMOTE_LO);
	assign lockout     = (ctl_reg == CTL_LOCAL_LO) || (ctl_reg == CTL_REMOTE_LO);

	// ==========================================================
	// Device clear and event flags
	// RULE8 selected clear
	assign clearHit = m.dcl || (m.sdc && listen_reg);

	// RULE5 clear pulse
	always_ff @(posedge clk) begin
		if (rst) begin
			clear_reg <= 1'b0;
		end else begin
			clear_reg <= clearHit;
		end
	end

	// A new error in the clearing cycle survives the clear
	// RULE6 clear errors
	always_ff @(posedge clk) begin
		if (rst) begin
			err_reg <= 1'b0;
		end else if (errEvent) begin
			err_reg <= 1'b1;
		end else if (clearHit) begin
			err_reg <= 1'b0;
		end
	end

	// Power-on event is left alone by device clear
	always_ff @(posedge clk) begin
		if (rst) begin
			pwrPend_reg <= PWR_PEND_RST;
			srqPwr_reg  <= PWR_SRQ_RST;
		end else if (powerOnAck) begin
			pwrPend_reg <= 1'b0;
			srqPwr_reg  <= 1'b0;
		end
	end

	// RULE7 withdraw request
	always_ff @(posedge clk) begin
		if (rst) begin
			srqOther_reg <= 1'b0;
		end else if (srqReq) begin
			srqOther_reg <= 1'b1;
		end else if (clearHit) begin
			srqOther_reg <= 1'b0;
		end
	end

	assign srq            = srqOther_reg || srqPwr_reg;
	assign errPending     = err_reg;
	assign powerOnPending = pwrPend_reg;
	assign devClear       = clear_reg;

	// ==========================================================
	// Talker output stage, one byte held for the source handshake
	// RULE2 send after ATN
	assign txSlot   = talk_reg && !atn && (!txValid_reg || txReady);
	assign outReady = txSlot && !spoll_reg && !clearHit;
	assign pollByte = {statusByte[7], srq, statusByte[5:0]};

	// Bytes under ATN or after a clear are dropped, not sent late
	always_ff @(posedge clk) begin
		if (rst || clearHit || atn || !talk_reg) begin
			txValid_reg <= 1'b0;
			txByte_reg  <= 8'h00;
			txEoi_reg   <= 1'b0;
		end else if (txSlot && spoll_reg) begin
			// RULE11 status byte
			txValid_reg <= 1'b1;
			txByte_reg  <= pollByte;
			txEoi_reg   <= 1'b0;
		end else if (txSlot) begin
			// RULE25 mark last byte
			txValid_reg <= outValid;
			txByte_reg  <= outByte;
			txEoi_reg   <= outValid && outLast;
		end
	end

	assign txValid = txValid_reg;
	assign txByte  = txByte_reg;
	assign txEoi   = txEoi_reg;

	// ==========================================================
	// Listener input stage
	assign rxAccept = listen_reg && !atn;
	assign rxTake   = rxValid && rxAccept && !clearHit;
	// RULE25 end on LF with EOI
	assign rxEnd    = rxEoi && (rxByte == CH_LF);

	always_ff @(posedge clk) begin
		if (rst || clearHit) begin
			dataValid_reg <= 1'b0;
			dataByte_reg  <= 8'h00;
			msgEnd_reg    <= 1'b0;
		end else begin
			dataValid_reg <= rxTake;
			msgEnd_reg    <= rxTake && rxEnd;
			if (rxTake) begin
				dataByte_reg <= rxByte;
			end
		end
	end

	assign dataValid  = dataValid_reg;
	assign dataByte   = dataByte_reg;
	assign msgEnd     = msgEnd_reg;
	assign talker     = talk_reg;
	assign listener   = listen_reg;
	assign serialPoll = spoll_reg;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_lloLocal;
		m.llo && ren && ctl_reg == CTL_LOCAL;
	endsequence

	sequence s_keysStillOn;
		panelKeysEn;
	endsequence

	property p_talk;
		m.mta && !ifc && !m.unt |=> talker;
	endproperty
	a_talk: assert property (p_talk) else $error("own talk address ignored"); // RULE1

	property p_listen;
		m.mla && !ifc && !m.unl |=> listener;
	endproperty
	a_listen: assert property (p_listen) else $error("own listen address ignored"); // RULE3

	property p_unl;
		m.unl |=> !listener;
	endproperty
	a_unl: assert property (p_unl) else $error("listener kept after unlisten"); // RULE13

	property p_ifc;
		ifc |=> !talker && !listener && !serialPoll;
	endproperty
	a_ifc: assert property (p_ifc) else $error("addressing kept after IFC"); // RULE14

	property p_lloLocal;
		s_lloLocal |=> s_keysStillOn ##0 lockout;
	endproperty
	a_lloLocal: assert property (p_lloLocal) else $error("local lockout lost keys"); // RULE10

	property p_lloRemote;
		m.llo && ren && ctl_reg == CTL_REMOTE |=> !panelKeysEn && lockout;
	endproperty
	a_lloRemote: assert property (p_lloRemote) else $error("keys live after lockout"); // RULE9

	property p_lockPanel;
		ctl_reg == CTL_REMOTE_LO && ren && panelOp && !m.gtl |=> remote && !panelKeysEn;
	endproperty
	a_lockPanel: assert property (p_lockPanel) else $error("panel left remote lockout"); // RULE20

	property p_ren;
		!ren |=> ctl_reg == CTL_LOCAL;
	endproperty
	a_ren: assert property (p_ren) else $error("control not local without REN"); // RULE21

	property p_pwrKeep;
		m.dcl && pwrPend_reg && !powerOnAck |=> powerOnPending && devClear;
	endproperty
	a_pwrKeep: assert property (p_pwrKeep) else $error("power-on event lost"); // RULE6

	property p_srqDrop;
		clearHit && !srqReq && !srqPwr_reg && !powerOnAck |=> !srq;
	endproperty
	a_srqDrop: assert property (p_srqDrop) else $error("service request not withdrawn"); // RULE7

	property p_sdcIgnored;
		m.sdc && !listen_reg && !m.dcl |=> !devClear;
	endproperty
	a_sdcIgnored: assert property (p_sdcIgnored) else $error("unaddressed clear acted"); // RULE8

	property p_addrOff;
		busAddr == ADDR_OFF && !talker && !listener && !remote
			|=> !talker && !listener && !remote;
	endproperty
	a_addrOff: assert property (p_addrOff) else $error("detached device addressed"); // RULE24

	property p_poll;
		txSlot && spoll_reg && !clearHit |=> txValid && txByte[SRQ_BIT] == $past(srq);
	endproperty
	a_poll: assert property (p_poll) else $error("poll byte not sent"); // RULE11
endmodule
`default_nettype wire

// [rtl/gpib_pkg.sv]
`default_nettype none
package gpib_pkg;
	// ==========================================================
	// Interface message codes, seven bits, parity bit ignored
	localparam logic [7:0] CODE_GTL  = 8'h01;
	localparam logic [7:0] CODE_SDC  = 8'h04;
	localparam logic [7:0] CODE_LLO  = 8'h11;
	localparam logic [7:0] CODE_DCL  = 8'h14;
	localparam logic [7:0] CODE_SPE  = 8'h18;
	localparam logic [7:0] CODE_SPD  = 8'h19;
	localparam logic [7:0] CODE_UNL  = 8'h3F;
	localparam logic [7:0] CODE_UNT  = 8'h5F;
	localparam logic [7:0] LISTEN_BASE = 8'h20;
	localparam logic [7:0] TALK_BASE   = 8'h40;
	localparam logic [1:0] TALK_GROUP  = 2'h2;
	// Bus address that detaches the device from the bus
	localparam logic [4:0] ADDR_OFF = 5'h1F;
	// ==========================================================
	// Program message characters
	localparam logic [7:0] CH_LF    = 8'h0A;
	localparam logic [7:0] CH_SPACE = 8'h20;
	localparam logic [7:0] CH_STAR  = 8'h2A;
	localparam logic [7:0] CH_COLON = 8'h3A;
	localparam logic [7:0] CH_SEMI  = 8'h3B;
	localparam logic [7:0] CH_QUERY = 8'h3F;
	// Position of the service request bit in the poll byte
	localparam int SRQ_BIT = 6;
	// ==========================================================
	// Header classes
	localparam logic [1:0] HDR_SIMPLE   = 2'h0;
	localparam logic [1:0] HDR_COMPOUND = 2'h1;
	localparam logic [1:0] HDR_COMMON   = 2'h2;
	// Reset values of the event flags
	localparam logic PWR_PEND_RST = 1'b1;
	localparam logic PWR_SRQ_RST  = 1'b1;
	// ==========================================================
	// Remote/local control states
	typedef enum logic [3:0] {
		CTL_LOCAL     = 4'b0001,
		CTL_REMOTE    = 4'b0010,
		CTL_LOCAL_LO  = 4'b0100,
		CTL_REMOTE_LO = 4'b1000
	} ctl_state_e;
endpackage
`default_nettype wire

// [rtl/header_classifier.sv]
`timescale 1ns/10ps
`default_nettype none
module header_classifier
	import gpib_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       flush,
	input  wire logic       byteValid,
	input  wire logic [7:0] byteIn,
	input  wire logic       msgEnd,
	output logic            hdrValid,
	output logic [1:0]      hdrKind,
	output logic            hdrQuery
);
	logic inArg;
	logic gotChar;
	logic sawStar;
	logic sawColon;
	logic sawQuery;
	logic hdrEnd;

	// A header ends at a space, a semicolon or the message end
	assign hdrEnd = byteValid && !inArg && (msgEnd || byteIn == CH_SPACE || byteIn == CH_SEMI);

	// ==========================================================
	// Header scan; a leading colon is skipped before any mnemonic
	// RULE22 unit layout
	always_ff @(posedge clk) begin
		if (rst || flush) begin
			inArg    <= 1'b0;
			gotChar  <= 1'b0;
			sawStar  <= 1'b0;
			sawColon <= 1'b0;
			sawQuery <= 1'b0;
		end else if (byteValid) begin
			if (inArg) begin
				inArg <= !(msgEnd || byteIn == CH_SEMI);
			end else if (hdrEnd) begin
				inArg    <= (byteIn == CH_SPACE) && !msgEnd;
				gotChar  <= 1'b0;
				sawStar  <= 1'b0;
				sawColon <= 1'b0;
				sawQuery <= 1'b0;
			end else if (byteIn == CH_STAR && !gotChar) begin
				sawStar <= 1'b1;
			end else if (byteIn == CH_COLON) begin
				sawColon <= gotChar;
			end else if (byteIn == CH_QUERY) begin
				sawQuery <= 1'b1;
			end else begin
				gotChar <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Class result, registered
	// RULE23 header class
	always_ff @(posedge clk) begin
		if (rst || flush) begin
			hdrValid <= 1'b0;
			hdrKind  <= HDR_SIMPLE;
			hdrQuery <= 1'b0;
		end else begin
			hdrValid <= hdrEnd && (gotChar || sawStar);
			if (hdrEnd) begin
				hdrKind  <= sawStar ? HDR_COMMON : (sawColon ? HDR_COMPOUND : HDR_SIMPLE);
				hdrQuery <= sawQuery;
			end
		end
	end
endmodule
`default_nettype wire

// [rtl/msg_decoder.sv]
`timescale 1ns/10ps
`default_nettype none
module msg_decoder
	import gpib_pkg::*;
(
	input  wire logic       cmdValid,
	input  wire logic [7:0] cmdByte,
	input  wire logic       atn,
	input  wire logic [4:0] busAddr,
	msg_if.dec              m
);
	logic addrOn;

	// Only bytes sent under ATN are interface messages
	function automatic logic hit(input logic [7:0] code, input logic v, input logic a,
		input logic [7:0] b);
		return v && a && (b[6:0] == code[6:0]);
	endfunction

	// ==========================================================
	// Address decode
	// RULE24 address off
	assign addrOn = (busAddr != ADDR_OFF);
	// RULE1 own talk
	assign m.mta = addrOn && hit(TALK_BASE | {3'h0, busAddr}, cmdValid, atn, cmdByte);
	// RULE3 own listen
	assign m.mla = addrOn && hit(LISTEN_BASE | {3'h0, busAddr}, cmdValid, atn, cmdByte);
	assign m.ota = cmdValid && atn && (cmdByte[6:5] == TALK_GROUP)
		&& (cmdByte[4:0] != busAddr) && (cmdByte[4:0] != ADDR_OFF);
	// RULE13 unaddress
	assign m.unl = hit(CODE_UNL, cmdValid, atn, cmdByte);
	assign m.unt = hit(CODE_UNT, cmdValid, atn, cmdByte);

	// ==========================================================
	// Addressed and universal commands
	assign m.gtl = hit(CODE_GTL, cmdValid, atn, cmdByte);
	assign m.sdc = hit(CODE_SDC, cmdValid, atn, cmdByte);
	assign m.dcl = hit(CODE_DCL, cmdValid, atn, cmdByte);
	assign m.llo = hit(CODE_LLO, cmdValid, atn, cmdByte);
	assign m.spe = hit(CODE_SPE, cmdValid, atn, cmdByte);
	assign m.spd = hit(CODE_SPD, cmdValid, atn, cmdByte);
endmodule
`default_nettype wire

// [rtl/msg_if.sv]
`timescale 1ns/10ps
`default_nettype none
// Decoded interface messages, one-cycle pulses
interface msg_if;
	logic mta;
	logic mla;
	logic ota;
	logic unl;
	logic unt;
	logic gtl;
	logic sdc;
	logic dcl;
	logic llo;
	logic spe;
	logic spd;
	modport dec (output mta, mla, ota, unl, unt, gtl, sdc, dcl, llo, spe, spd);
	modport ctl (input mta, mla, ota, unl, unt, gtl, sdc, dcl, llo, spe, spd);
endinterface
`default_nettype wire

// [verification/gpib_acceptor_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Acceptor side of the source handshake, able to stall
module gpib_acceptor_model (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       stall,
	input  wire logic       txValid,
	input  wire logic [7:0] txByte,
	input  wire logic       txEoi,
	output logic            txReady
);
	logic [8:0] got[$];
	// take bytes
	// Ready drops after each take, so a held byte is never counted twice
	always @(posedge clk) begin
		if (rst) begin
			txReady <= 1'b0;
		end else begin
			if (txValid && txReady) begin
				got.push_back({txEoi, txByte});
			end
			txReady <= txValid && !txReady && !stall;
		end
	end
endmodule
`default_nettype wire

// [verification/gpib_interface_message_control_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module gpib_interface_message_control_tb
	import gpib_pkg::*;
;
	localparam logic [4:0] MY = 5'h05;
	localparam logic [7:0] MTA = TALK_BASE | {3'h0, MY};
	localparam logic [7:0] MLA = LISTEN_BASE | {3'h0, MY};
	logic clk = 1'b0, rst = 1'b1, atn = 1'b1, ren = 1'b1, ifc = 1'b0, stall = 1'b0;
	logic [4:0] busAddr = MY;
	logic cmdValid = 1'b0, rxValid = 1'b0, rxEoi = 1'b0, outValid = 1'b0, outLast = 1'b0;
	logic [7:0] cmdByte = 8'h00, rxByte = 8'h00, outByte = 8'h00, statusByte = 8'h00;
	logic panelOp = 1'b0, errEvent = 1'b0, powerOnAck = 1'b0, srqReq = 1'b0;
	logic rxAccept, outReady, txValid, txEoi, txReady, panelKeysEn, remote, lockout;
	logic talker, listener, serialPoll, devClear, errPending, powerOnPending, srq;
	logic dataValid, msgEnd, hdrValid, hdrQuery;
	logic [7:0] txByte, dataByte;
	logic [1:0] hdrKind;
	logic [2:0] hdrLog[$];
	logic [7:0] dataLog[$];
	int fails = 0, samplesChecked = 0, cycles = 0, clrCnt = 0, endCnt = 0, dataCnt = 0;
	// ==========================================================
	// Clock, design and far-side acceptor
	always #2 clk = ~clk;
	gpib_interface_message_control dut (.clk(clk), .rst(rst), .atn(atn), .ren(ren), .ifc(ifc),
		.busAddr(busAddr), .cmdValid(cmdValid), .cmdByte(cmdByte), .rxValid(rxValid),
		.rxByte(rxByte), .rxEoi(rxEoi), .rxAccept(rxAccept), .outValid(outValid),
		.outByte(outByte), .outLast(outLast), .outReady(outReady), .statusByte(statusByte),
		.txValid(txValid), .txByte(txByte), .txEoi(txEoi), .txReady(txReady),
		.panelOp(panelOp), .panelKeysEn(panelKeysEn), .remote(remote), .lockout(lockout),
		.talker(talker), .listener(listener), .serialPoll(serialPoll), .devClear(devClear),
		.errEvent(errEvent), .errPending(errPending), .powerOnAck(powerOnAck),
		.powerOnPending(powerOnPending), .srqReq(srqReq), .srq(srq), .dataValid(dataValid),
		.dataByte(dataByte), .msgEnd(msgEnd), .hdrValid(hdrValid), .hdrKind(hdrKind),
		.hdrQuery(hdrQuery));
	gpib_acceptor_model pm (.clk(clk), .rst(rst), .stall(stall), .txValid(txValid),
		.txByte(txByte), .txEoi(txEoi), .txReady(txReady));
	// Pulse monitors; one-cycle outputs are counted where they stand
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (devClear) clrCnt <= clrCnt + 1;
		if (msgEnd) endCnt <= endCnt + 1;
		if (dataValid) dataCnt <= dataCnt + 1;
		if (dataValid) dataLog.push_back(dataByte);
		if (hdrValid) hdrLog.push_back({hdrQuery, hdrKind});
		if (cycles == 5000) begin
			fails++;
			end_sim();
		end
	end
	// ==========================================================
	// Shared tasks
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samplesChecked++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmd(input logic [7:0] b);
		@(posedge clk);
		cmdValid <= 1'b1;
		cmdByte <= b;
		@(posedge clk);
		cmdValid <= 1'b0;
		@(negedge clk);
	endtask
	// Pulses one of the single-cycle inputs: 0 panel, 1 error, 2 power ack, 3 srq, 4 ifc
	task automatic pulse(input int which);
		@(posedge clk);
		case (which)
			0: panelOp <= 1'b1;
			1: errEvent <= 1'b1;
			2: powerOnAck <= 1'b1;
			3: srqReq <= 1'b1;
			default: ifc <= 1'b1;
		endcase
		@(posedge clk);
		{panelOp, errEvent, powerOnAck, srqReq, ifc} <= 5'h00;
		repeat (2) @(negedge clk);
	endtask
	task automatic ctl(input logic [2:0] exp);
		chk({5'h00, panelKeysEn, remote, lockout}, {5'h00, exp});
	endtask
	// Holds the byte until the edge at which outReady is high
	task automatic sendOut(input logic [7:0] b, input logic last);
		@(posedge clk);
		outValid <= 1'b1;
		outByte <= b;
		outLast <= last;
		do @(negedge clk); while (!outReady && cycles < 5000);
		@(posedge clk);
		outValid <= 1'b0;
	endtask
	task automatic waitGot(input int n);
		while (pm.got.size() < n && cycles < 5000) @(negedge clk);
	endtask
	task automatic rxStr(input string s);
		for (int i = 0; i < s.len(); i++) begin
			@(posedge clk);
			rxValid <= 1'b1;
			rxByte <= s[i];
		end
		@(posedge clk);
		rxByte <= CH_LF;
		rxEoi <= 1'b1;
		@(posedge clk);
		rxValid <= 1'b0;
		rxEoi <= 1'b0;
		repeat (3) @(negedge clk);
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_addr;
		cmd(MTA); chk({7'h00, talker}, 8'h01);
		cmd(MLA); chk({5'h00, talker, listener, remote}, 8'h03);
		cmd(CODE_UNL); chk({7'h00, listener}, 8'h00);
		cmd(MTA); cmd(CODE_UNT); chk({7'h00, talker}, 8'h00);
		cmd(MTA); cmd(TALK_BASE | 8'h09); chk({7'h00, talker}, 8'h00);
		cmd(MLA); pulse(4); chk({6'h00, talker, listener}, 8'h00);
	endtask
	task automatic t_lock;
		pulse(0); ctl(3'b100);
		cmd(MLA); cmd(CODE_GTL); ctl(3'b100);
		cmd(CODE_LLO); pulse(0); ctl(3'b101);
		cmd(MLA); ctl(3'b011);
		pulse(0); ctl(3'b011);
		@(posedge clk); ren <= 1'b0; repeat (2) @(negedge clk); ctl(3'b100);
		@(posedge clk); ren <= 1'b1;
		cmd(MLA); cmd(CODE_LLO); ctl(3'b011);
		@(posedge clk); ren <= 1'b0; @(posedge clk); ren <= 1'b1;
	endtask
	task automatic t_clear;
		int c;
		cmd(CODE_UNL); pulse(1); pulse(3); c = clrCnt;
		cmd(CODE_SDC); @(negedge clk); chk(8'(clrCnt - c), 8'h00);
		chk({7'h00, errPending}, 8'h01);
		cmd(CODE_DCL); @(negedge clk); chk(8'(clrCnt - c), 8'h01);
		chk({6'h00, errPending, powerOnPending}, 8'h01);
		chk({7'h00, srq}, 8'h01);
		pulse(2); chk({6'h00, powerOnPending, srq}, 8'h00);
		pulse(3); cmd(MLA); cmd(CODE_SDC); @(negedge clk);
		chk(8'(clrCnt - c), 8'h02);
		chk({7'h00, srq}, 8'h00);
		cmd(CODE_UNL);
	endtask
	task automatic t_talk;
		cmd(MTA); pm.got.delete();
		@(posedge clk); atn <= 1'b0; stall <= 1'b1;
		sendOut(8'h41, 1'b0); repeat (5) @(posedge clk);
		stall <= 1'b0; sendOut(CH_LF, 1'b1); waitGot(2);
		chk(pm.got[0][7:0], 8'h41);
		chk({7'h00, pm.got[0][8]}, 8'h00);
		chk(pm.got[1][7:0], CH_LF);
		chk({7'h00, pm.got[1][8]}, 8'h01);
		@(posedge clk); atn <= 1'b1;
	endtask
	task automatic t_poll;
		pulse(3); cmd(CODE_SPE); chk({7'h00, serialPoll}, 8'h01);
		pm.got.delete(); @(posedge clk); statusByte <= 8'h05; atn <= 1'b0;
		waitGot(1); @(posedge clk); atn <= 1'b1;
		chk(pm.got[0][7:0], 8'h45);
		chk({7'h00, pm.got[0][8]}, 8'h00);
		cmd(CODE_SPD); chk({6'h00, serialPoll, talker}, 8'h01);
		cmd(CODE_UNT);
	endtask
	task automatic t_hdr;
		cmd(MLA); @(posedge clk); atn <= 1'b0;
		@(negedge clk); chk({7'h00, rxAccept}, 8'h01);
		rxStr("*IDN?"); rxStr(":CH1:GAIN 5;DESE");
		chk(8'(hdrLog.size()), 8'h03);
		chk({5'h00, hdrLog[0]}, {5'h00, 1'b1, HDR_COMMON});
		chk({5'h00, hdrLog[1]}, {5'h00, 1'b0, HDR_COMPOUND});
		chk({5'h00, hdrLog[2]}, {5'h00, 1'b0, HDR_SIMPLE});
		chk(8'(endCnt), 8'h02);
		chk(8'(dataCnt), 8'd23);
		chk(dataLog[0], CH_STAR);
		chk(dataLog[5], CH_LF);
		chk(dataLog[6], CH_COLON);
		@(posedge clk); atn <= 1'b1;
		@(negedge clk); chk({7'h00, rxAccept}, 8'h00);
	endtask
	// Detached address: own codes at 31 coincide with the unaddress codes
	task automatic t_off;
		cmd(CODE_UNL); pulse(0); @(posedge clk); busAddr <= ADDR_OFF;
		cmd(MLA); cmd(MTA); cmd(LISTEN_BASE | 8'h1F);
		chk({5'h00, talker, listener, remote}, 8'h00);
		@(posedge clk); busAddr <= MY;
	endtask
	task automatic end_sim;
		if (fails == 0 && samplesChecked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk({talker, listener, serialPoll, panelKeysEn, remote, lockout, powerOnPending, srq},
			8'h13);
		t_addr();
		t_lock();
		t_clear();
		t_talk();
		t_poll();
		t_hdr();
		t_off();
		end_sim();
	end
endmodule
`default_nettype wire
